// file: src/cida_pkg.sv
// Constants, types and defaults for the configuration index/data access block
//
// Behaviour
// - Three config registers: enable, address, power/test.
// - Reset loads strap-selected defaults into all registers.
// - Index selects register used by data accesses.
// - First index read after reset returns ID.
// - Second index read after reset returns zero.
// - Index bits two to six read zero.
// - Commit only on second consecutive data write.
// - Single reads allowed anytime, never disturb registers.
// - Index read returns last written index value.
// - Data read returns selected register contents.
// - Five straps pick one of thirty-two sets.
// - Codes 0-5: enable 4f/cf, full address list.
// - Codes 6-11: enable 4b/cb, one serial port.
// - Codes 12-15: enable 0f, no drive interface.
// - Codes 16-19 enable 49/c9; 20-23 enable 07.
// - Codes 24-29: enable 47/c7, drive interface.
// - Power/test default 00 except all-ones code.
// - Code 31: nothing enabled, power/test 02, crystal stop.
// - Location strap picks 398h/399h or 26eh/26fh.
`default_nettype none

package cida_pkg;

  // ---------------------------------------------------------------
  // Bus locations
  // ---------------------------------------------------------------
  localparam logic [9:0] CIDA_INDEX_ADDR_LOW = 10'h398;
  localparam logic [9:0] CIDA_DATA_ADDR_LOW = 10'h399;
  localparam logic [9:0] CIDA_INDEX_ADDR_HIGH = 10'h26e;
  localparam logic [9:0] CIDA_DATA_ADDR_HIGH = 10'h26f;

  // ---------------------------------------------------------------
  // Index field layout and selections
  // ---------------------------------------------------------------
  localparam logic [7:0] CIDA_INDEX_RW_MASK = 8'h83;
  localparam logic [7:0] CIDA_INDEX_RESET = 8'h00;
  localparam logic [7:0] CIDA_IDX_ENABLE = 8'h00;
  localparam logic [7:0] CIDA_IDX_ADDRESS = 8'h01;
  localparam logic [7:0] CIDA_IDX_POWER = 8'h02;
  localparam logic [7:0] CIDA_UNMAPPED_READ = 8'h00;
  localparam logic [7:0] CIDA_READ_RESET = 8'h00;
  localparam int CIDA_PWR_XTAL_BIT = 1;

  // ---------------------------------------------------------------
  // Strap default values
  // ---------------------------------------------------------------
  localparam logic [7:0] CIDA_EN_ALL_PRIMARY = 8'h4f;
  localparam logic [7:0] CIDA_EN_ALL_SECONDARY = 8'hcf;
  localparam logic [7:0] CIDA_EN_ONE_PRIMARY = 8'h4b;
  localparam logic [7:0] CIDA_EN_ONE_SECONDARY = 8'hcb;
  localparam logic [7:0] CIDA_EN_NO_DRIVE = 8'h0f;
  localparam logic [7:0] CIDA_EN_DISK_PRIMARY = 8'h49;
  localparam logic [7:0] CIDA_EN_DISK_SECONDARY = 8'hc9;
  localparam logic [7:0] CIDA_EN_SERIAL = 8'h07;
  localparam logic [7:0] CIDA_EN_DRV_PRIMARY = 8'h47;
  localparam logic [7:0] CIDA_EN_DRV_SECONDARY = 8'hc7;
  localparam logic [7:0] CIDA_EN_DISK_ONLY = 8'h08;
  localparam logic [7:0] CIDA_EN_NONE = 8'h00;
  localparam logic [7:0] CIDA_PWR_CLOCKS = 8'h00;
  localparam logic [7:0] CIDA_PWR_XTAL = 8'h02;
  localparam logic [7:0] CIDA_ADR_DISK_ONLY = 8'h10;
  localparam logic [7:0] CIDA_ADR_NONE = 8'h10;
  // Address lists per group, in strap code order
  localparam logic [47:0] CIDA_ADR_FULL = 48'h10_11_11_39_24_38;
  localparam logic [47:0] CIDA_ADR_ONE = 48'h00_01_01_09_08_08;
  localparam logic [31:0] CIDA_ADR_NODRV = 32'h10_11_39_24;
  localparam logic [31:0] CIDA_ADR_DISK = 32'h00_01_01_00;
  localparam logic [31:0] CIDA_ADR_SER = 32'h10_11_39_24;
  localparam logic [47:0] CIDA_ADR_DRV = 48'h10_11_11_39_24_38;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [9:0] addr;
    logic aen;
    logic ior_n;
    logic iow_n;
    logic [7:0] wdata;
  } cida_isa_req_t;

  typedef struct packed {
    logic [7:0] function_enable_reg;
    logic [7:0] function_address_reg;
    logic [7:0] power_test_reg;
  } cida_cfg_regs_t;

endpackage : cida_pkg

`default_nettype wire

// file: src/cida_strap_defaults.sv
// Strap code to default configuration register set
`timescale 1ns/1ps
`default_nettype none

module cida_strap_defaults (
  // Strap code
  input wire logic [4:0] default_select_straps,
  // Default register set
  output var cida_pkg::cida_cfg_regs_t defaults
);
  import cida_pkg::*;

  function automatic logic [7:0] pick6(input logic [47:0] tbl, input logic [2:0] n);
    pick6 = tbl[8'(47 - 8 * n) -: 8];
  endfunction

  function automatic logic [7:0] pick4(input logic [31:0] tbl, input logic [1:0] n);
    pick4 = tbl[8'(31 - 8 * n) -: 8];
  endfunction

  always_comb begin
    defaults.power_test_reg = CIDA_PWR_CLOCKS;
    defaults.function_enable_reg = CIDA_EN_NONE;
    defaults.function_address_reg = CIDA_ADR_NONE;
    unique case (default_select_straps)
      5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05: begin
        defaults.function_address_reg = pick6(CIDA_ADR_FULL, default_select_straps[2:0]);
        defaults.function_enable_reg = (default_select_straps == 5'h02 || default_select_straps == 5'h05) ?
          CIDA_EN_ALL_SECONDARY : CIDA_EN_ALL_PRIMARY;
      end
      5'h06, 5'h07, 5'h08, 5'h09, 5'h0a, 5'h0b: begin
        defaults.function_address_reg = pick6(CIDA_ADR_ONE, 3'(default_select_straps - 5'h06));
        defaults.function_enable_reg = (default_select_straps == 5'h08 || default_select_straps == 5'h0b) ?
          CIDA_EN_ONE_SECONDARY : CIDA_EN_ONE_PRIMARY;
      end
      5'h0c, 5'h0d, 5'h0e, 5'h0f: begin
        defaults.function_address_reg = pick4(CIDA_ADR_NODRV, default_select_straps[1:0]);
        defaults.function_enable_reg = CIDA_EN_NO_DRIVE;
      end
      5'h10, 5'h11, 5'h12, 5'h13: begin
        defaults.function_address_reg = pick4(CIDA_ADR_DISK, default_select_straps[1:0]);
        defaults.function_enable_reg = default_select_straps[1] ?
          CIDA_EN_DISK_SECONDARY : CIDA_EN_DISK_PRIMARY;
      end
      5'h14, 5'h15, 5'h16, 5'h17: begin
        defaults.function_address_reg = pick4(CIDA_ADR_SER, default_select_straps[1:0]);
        defaults.function_enable_reg = CIDA_EN_SERIAL;
      end
      5'h18, 5'h19, 5'h1a, 5'h1b, 5'h1c, 5'h1d: begin
        defaults.function_address_reg = pick6(CIDA_ADR_DRV, 3'(default_select_straps - 5'h18));
        defaults.function_enable_reg = (default_select_straps == 5'h1a || default_select_straps == 5'h1d) ?
          CIDA_EN_DRV_SECONDARY : CIDA_EN_DRV_PRIMARY;
      end
      5'h1e: begin
        defaults.function_enable_reg = CIDA_EN_DISK_ONLY;
        defaults.function_address_reg = CIDA_ADR_DISK_ONLY;
      end
      5'h1f: begin
        defaults.function_enable_reg = CIDA_EN_NONE;
        defaults.function_address_reg = CIDA_ADR_NONE;
        defaults.power_test_reg = CIDA_PWR_XTAL;
      end
    endcase
  end

endmodule // cida_strap_defaults

`default_nettype wire

// file: src/cida_config_access.sv
// Configuration register bank reached through an index/data pair on the I/O bus
`timescale 1ns/1ps
`default_nettype none

module cida_config_access #(
  // Arbitrary identification value returned by the first index read
  parameter logic [7:0] ID_BYTE = 8'h5a
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Straps and power control
  input wire logic [4:0] default_select_straps,
  input wire logic index_location_strap,
  input wire logic power_down_input_n,
  // I/O bus request
  input wire cida_pkg::cida_isa_req_t bus,
  // I/O bus read data, two-way data pins
  output logic [7:0] data_out,
  output logic data_oe_n,
  // Configuration outputs
  output var cida_pkg::cida_cfg_regs_t cfg,
  output logic clock_stop,
  output logic xtal_stop
);
  import cida_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    cida_cfg_regs_t regs;
    logic [7:0] index;
    logic id_pending;
    logic write_armed;
    logic location_high;
    logic ior_n_prev;
    logic iow_n_prev;
    logic [7:0] rdata;
    logic driving;
  } cida_state_t;

  cida_state_t st_q;
  cida_state_t st_d;
  cida_cfg_regs_t strap_defaults;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic addr_hit(input cida_isa_req_t req, input logic [9:0] loc);
    addr_hit = !req.aen && (req.addr == loc);
  endfunction

  function automatic logic [7:0] cfg_read(input cida_cfg_regs_t regs, input logic [7:0] idx);
    unique case (idx)
      CIDA_IDX_ENABLE: cfg_read = regs.function_enable_reg;
      CIDA_IDX_ADDRESS: cfg_read = regs.function_address_reg;
      CIDA_IDX_POWER: cfg_read = regs.power_test_reg;
      default: cfg_read = CIDA_UNMAPPED_READ;
    endcase
  endfunction

  cida_strap_defaults u_defaults (
    .default_select_straps(default_select_straps),
    .defaults(strap_defaults)
  );

  // ---------------------------------------------------------------
  // Address decode and strobe edges
  // ---------------------------------------------------------------
  logic [9:0] index_loc;
  logic [9:0] data_loc;
  logic hit_index;
  logic hit_data;
  logic rd_start;
  logic wr_start;

  always_comb begin
    index_loc = st_q.location_high ? CIDA_INDEX_ADDR_HIGH : CIDA_INDEX_ADDR_LOW;
    data_loc = st_q.location_high ? CIDA_DATA_ADDR_HIGH : CIDA_DATA_ADDR_LOW;
    hit_index = addr_hit(bus, index_loc);
    hit_data = addr_hit(bus, data_loc);
    // Act once per strobe, on its leading edge; a long strobe is one access
    rd_start = !bus.ior_n && st_q.ior_n_prev && (hit_index || hit_data);
    // Both strobes at once is a bus fault; the read wins and the write is dropped
    wr_start = !bus.iow_n && st_q.iow_n_prev && bus.ior_n && (hit_index || hit_data);
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.ior_n_prev = bus.ior_n;
    st_d.iow_n_prev = bus.iow_n;
    if (bus.ior_n) begin
      st_d.driving = 1'b0;
    end
    if (reset) begin
      st_d.regs = strap_defaults;
      st_d.index = CIDA_INDEX_RESET;
      st_d.id_pending = 1'b1;
      st_d.write_armed = 1'b0;
      st_d.location_high = index_location_strap;
      st_d.ior_n_prev = 1'b1;
      st_d.iow_n_prev = 1'b1;
      st_d.rdata = CIDA_READ_RESET;
      st_d.driving = 1'b0;
    end else if (rd_start) begin
      st_d.driving = 1'b1;
      // A read never touches the bank, but it does break a write pair
      st_d.write_armed = 1'b0;
      if (hit_index) begin
        if (st_q.id_pending) begin
          st_d.rdata = ID_BYTE;
          st_d.id_pending = 1'b0;
        end else begin
          st_d.rdata = st_q.index & CIDA_INDEX_RW_MASK;
        end
      end else begin
        st_d.rdata = cfg_read(st_q.regs, st_q.index);
      end
    end else if (wr_start) begin
      if (hit_index) begin
        st_d.index = bus.wdata & CIDA_INDEX_RW_MASK;
        st_d.write_armed = 1'b0;
      end else if (!st_q.write_armed) begin
        // First of a pair only arms; nothing is stored yet
        st_d.write_armed = 1'b1;
      end else begin
        // Second consecutive write commits; the pair is then spent
        st_d.write_armed = 1'b0;
        unique case (st_q.index)
          CIDA_IDX_ENABLE: st_d.regs.function_enable_reg = bus.wdata;
          CIDA_IDX_ADDRESS: st_d.regs.function_address_reg = bus.wdata;
          CIDA_IDX_POWER: st_d.regs.power_test_reg = bus.wdata;
          default: st_d.regs = st_q.regs;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    st_q <= st_d;
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  always_comb begin
    data_out = st_q.rdata;
    // Released as soon as the read strobe goes away, so no bus fight follows
    data_oe_n = !(st_q.driving && !bus.ior_n);
    cfg = st_q.regs;
    clock_stop = !power_down_input_n;
    xtal_stop = !power_down_input_n && st_q.regs.power_test_reg[CIDA_PWR_XTAL_BIT];
  end

endmodule // cida_config_access

`default_nettype wire

// file: sim/cida_config_access_sva.sv
// Port checks for the configuration index/data access block
`timescale 1ns/1ps
`default_nettype none

module cida_config_access_sva #(
  parameter logic [7:0] ID_BYTE = 8'h5a
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Straps and power control
  input wire logic [4:0] default_select_straps,
  input wire logic index_location_strap,
  input wire logic power_down_input_n,
  // Bus side
  input wire cida_pkg::cida_isa_req_t bus,
  input wire logic [7:0] data_out,
  input wire logic data_oe_n,
  // Configuration outputs
  input wire cida_pkg::cida_cfg_regs_t cfg,
  input wire logic clock_stop,
  input wire logic xtal_stop
);
  import cida_pkg::*;
  logic [9:0] idx_a;
  logic [9:0] dat_a;
  logic rd_ok;
  assign idx_a = index_location_strap ? CIDA_INDEX_ADDR_HIGH : CIDA_INDEX_ADDR_LOW;
  assign dat_a = index_location_strap ? CIDA_DATA_ADDR_HIGH : CIDA_DATA_ADDR_LOW;
  // Plain read only: a write strobe or a DMA cycle voids it
  assign rd_ok = bus.iow_n && !bus.aen;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  AST_CLOCK_STOP: assert property (clock_stop == !power_down_input_n)
    else $error("clock stop does not follow power down");
  AST_XTAL_STOP: assert property (xtal_stop == (!power_down_input_n && cfg.power_test_reg[CIDA_PWR_XTAL_BIT]))
    else $error("crystal stop mismatch");
  AST_OE_IDLE: assert property (bus.ior_n |-> data_oe_n)
    else $error("data pins driven without read strobe");
  AST_RD_ANSWER: assert property ($fell(bus.ior_n) && rd_ok && (bus.addr == idx_a || bus.addr == dat_a) |-> ##2 !data_oe_n)
    else $error("read not answered");
  AST_IDX_RESERVED: assert property ($fell(bus.ior_n) && rd_ok && bus.addr == idx_a |-> ##2 ((data_out & 8'h7c) == 8'h00 || data_out == ID_BYTE))
    else $error("reserved index bits set");
  AST_DOUT_HOLD: assert property (!data_oe_n && !$past(data_oe_n) |-> $stable(data_out))
    else $error("read data moved during read");
  AST_READ_KEEPS_CFG: assert property ($fell(bus.ior_n) && bus.iow_n |-> ##1 $stable(cfg)[*3])
    else $error("read changed configuration");
  AST_CFG_BY_WRITE: assert property (!reset ##1 (!reset && $changed(cfg)) |-> !$past(bus.iow_n))
    else $error("configuration changed without write");
  AST_DMA_IGNORED: assert property ($fell(bus.iow_n) && bus.aen |-> ##1 $stable(cfg)[*3])
    else $error("DMA write changed configuration");
  // ----------------------------------------
  // Coverage
  // ----------------------------------------
  COV_ID: cover property ($fell(bus.ior_n) ##2 (data_out == ID_BYTE && !data_oe_n));
  COV_COMMIT: cover property ($changed(cfg));
  COV_XTAL: cover property (xtal_stop);
endmodule // cida_config_access_sva

bind cida_config_access cida_config_access_sva #(.ID_BYTE(ID_BYTE)) u_cida_config_access_sva (
  .clk(clk), .reset(reset), .default_select_straps(default_select_straps),
  .index_location_strap(index_location_strap), .power_down_input_n(power_down_input_n), .bus(bus),
  .data_out(data_out), .data_oe_n(data_oe_n), .cfg(cfg), .clock_stop(clock_stop), .xtal_stop(xtal_stop)
);

`default_nettype wire

// file: sim/cida_host_model.sv
// Host model issuing I/O reads and writes
`timescale 1ns/1ps
`default_nettype none

module cida_host_model (
  // Clock
  input wire logic clk,
  // Bus request and data pins
  output var cida_pkg::cida_isa_req_t bus,
  input wire logic [7:0] data_out,
  input wire logic data_oe_n
);
  import cida_pkg::*;
  logic [7:0] last_q = 8'h00;
  logic [7:0] pins;
  // Released pins show the inverse of the last value, never a stale copy
  assign pins = data_oe_n ? ~last_q : data_out;
  initial bus = '{addr: 10'h000, aen: 1'b0, ior_n: 1'b1, iow_n: 1'b1, wdata: 8'h00};

  // Strobe held two edges, then high two edges before the next access
  task automatic wr(input logic [9:0] a, input logic [7:0] d, input logic dma);
    @(posedge clk);
    #1 bus.addr = a;
    bus.wdata = d;
    bus.aen = dma;
    bus.iow_n = 1'b0;
    repeat (2) @(posedge clk);
    #1 bus.iow_n = 1'b1;
    bus.aen = 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [9:0] a, output logic [7:0] d);
    @(posedge clk);
    #1 bus.addr = a;
    bus.ior_n = 1'b0;
    repeat (3) @(posedge clk);
    #1 d = pins;
    last_q = d;
    bus.ior_n = 1'b1;
    @(posedge clk);
  endtask
endmodule // cida_host_model

`default_nettype wire

// file: sim/cida_config_access_tb.sv
// Testbench for the configuration index/data access block
`timescale 1ns/1ps
`default_nettype none

module cida_config_access_tb;
  import cida_pkg::*;
  localparam logic [7:0] ID = 8'hc3; // Arbitrary identification value
  logic clk, reset, loc, pd_n;
  logic [4:0] code;
  logic [7:0] rd, data_out;
  logic data_oe_n, clock_stop, xtal_stop;
  cida_isa_req_t bus;
  cida_cfg_regs_t cfg;
  int n_fail = 0;
  int tests_run = 0;
  // Strap code, enable, address, power/test
  logic [31:0] tbl [10] = '{32'h004f1000, 32'h05cf3800, 32'h064b0000, 32'h0bcb0800, 32'h0c0f1000,
    32'h12c90100, 32'h14071000, 32'h1dc73800, 32'h1e081000, 32'h1f001002};

  cida_config_access #(.ID_BYTE(ID)) u_cida_config_access (.clk(clk), .reset(reset),
    .default_select_straps(code), .index_location_strap(loc), .power_down_input_n(pd_n), .bus(bus),
    .data_out(data_out), .data_oe_n(data_oe_n), .cfg(cfg), .clock_stop(clock_stop), .xtal_stop(xtal_stop));
  cida_host_model u_cida_host_model (.clk(clk), .bus(bus), .data_out(data_out), .data_oe_n(data_oe_n));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [9:0] ia(input logic d);
    return loc ? (d ? CIDA_DATA_ADDR_HIGH : CIDA_INDEX_ADDR_HIGH) : (d ? CIDA_DATA_ADDR_LOW : CIDA_INDEX_ADDR_LOW);
  endfunction

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Hang guard
  initial begin
    #200000;
    n_fail++;
    report_and_stop;
  end

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    reset = 1'b1;
    code = 5'h00;
    loc = 1'b0;
    pd_n = 1'b1;
    for (int i = 0; i < 10; i++) begin
      #1 reset = 1'b1;
      code = tbl[i][28:24];
      loc = i[0];
      repeat (20) @(posedge clk);
      #1 reset = 1'b0;
      for (int b = 0; b < 3; b++) chk("defaults", tbl[i][b*8 +: 8], cfg[b*8 +: 8]);
      u_cida_host_model.rd(ia(1'b0), rd);
      chk("first index read", ID, rd);
      u_cida_host_model.rd(ia(1'b0), rd);
      chk("second index read", 8'h00, rd);
      u_cida_host_model.rd(ia(1'b1), rd);
      chk("data read", tbl[i][23:16], rd);
    end
    #1 pd_n = 1'b0;
    #1 chk("crystal stop", 8'h01, {7'h0, xtal_stop});
    chk("clock stop", 8'h01, {7'h0, clock_stop});
    u_cida_host_model.wr(ia(1'b0), 8'hfd, 1'b0);
    u_cida_host_model.rd(ia(1'b0), rd);
    chk("masked index", 8'h81, rd);
    u_cida_host_model.rd(ia(1'b1), rd);
    chk("unmapped data", 8'h00, rd);
    u_cida_host_model.wr(ia(1'b0), 8'h01, 1'b0);
    u_cida_host_model.wr(ia(1'b1), 8'h55, 1'b0);
    u_cida_host_model.rd(ia(1'b0), rd);
    u_cida_host_model.wr(ia(1'b1), 8'h66, 1'b0);
    u_cida_host_model.rd(ia(1'b1), rd);
    chk("address after broken pair", 8'h10, rd);
    u_cida_host_model.wr(ia(1'b1), 8'h77, 1'b0);
    u_cida_host_model.wr(ia(1'b1), 8'h99, 1'b0);
    u_cida_host_model.rd(ia(1'b1), rd);
    chk("address after pair", 8'h99, rd);
    u_cida_host_model.wr(ia(1'b1), 8'h11, 1'b0);
    u_cida_host_model.wr(ia(1'b1), 8'h22, 1'b1);
    u_cida_host_model.wr(ia(1'b1), 8'h22, 1'b1);
    u_cida_host_model.rd(ia(1'b1), rd);
    chk("address after lone and DMA writes", 8'h99, rd);
    u_cida_host_model.wr(ia(1'b0), 8'h02, 1'b0);
    u_cida_host_model.wr(ia(1'b1), 8'ha5, 1'b0);
    u_cida_host_model.wr(ia(1'b1), 8'ha5, 1'b0);
    u_cida_host_model.rd(ia(1'b1), rd);
    chk("power/test", 8'ha5, rd);
    chk("crystal stop cleared", 8'h00, {7'h0, xtal_stop});
    report_and_stop;
  end
endmodule // cida_config_access_tb

`default_nettype wire
